//--- core/thumb_alu_shift_move_extend.sv
// The Wishbone interface to the registers and the address map were left to the implementer.
`default_nettype none
module thumb_alu_shift_move_extend
  import alu_pkg::*;
(
  input wire logic clk_i,                // 40 MHz core clock
  input wire logic rst_i,                // Synchronous reset, active high
  input wire logic op_valid_i,           // One-cycle operation request
  input wire op_t op_i,                  // Operation code
  input wire logic [31:0] first_src_i,   // First source, or value to shift or move
  input wire logic [31:0] second_src_i,  // Second source, or shift amount register
  input wire logic [7:0] imm_i,          // Immediate constant or shift length
  input wire logic imm_form_i,           // Use immediate instead of second source for compare and for shifts other than rotate
  input wire logic [3:0] dest_idx_i,     // Destination register number
  input wire logic wb_cyc_i,             // Wishbone cycle
  input wire logic wb_stb_i,             // Wishbone strobe
  input wire logic wb_we_i,              // Wishbone write enable
  input wire logic [7:0] wb_adr_i,       // Wishbone byte address
  input wire logic [3:0] wb_sel_i,       // Wishbone byte selects
  input wire logic [31:0] wb_dat_i,      // Wishbone write data
  output logic [31:0] wb_dat_o,          // Wishbone read data
  output logic wb_ack_o,                 // Wishbone acknowledge
  output logic [31:0] result_o,          // Result for the register file
  output logic wr_en_o,                  // Register file write pulse
  output logic [3:0] wr_idx_o,           // Register to write
  output logic done_o,                   // Operation finished pulse
  output logic branch_o,                 // Branch pulse from move to PC
  output logic [31:0] branch_addr_o,     // Branch target, bit 0 clear
  output logic flag_n_o,                 // Negative flag
  output logic flag_z_o,                 // Zero flag
  output logic flag_c_o,                 // Carry flag
  output logic flag_v_o                  // Overflow flag
);
  typedef struct packed {
    logic [31:0] result;
    logic wr_en;
    logic [3:0] wr_idx;
    logic done;
    logic branch;
    logic [31:0] branch_addr;
    logic fn;
    logic fz;
    logic fc;
    logic fv;
    logic [31:0] op_count;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Add with carry in, carry out in the top bit
  function automatic logic [32:0] add_carry(input logic [31:0] x, input logic [31:0] y, input logic cin);
    add_carry = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
  endfunction

  // Signed overflow of an addition
  function automatic logic add_ovf(input logic [31:0] x, input logic [31:0] y, input logic [31:0] r);
    add_ovf = (x[31] == y[31]) && (r[31] != x[31]);
  endfunction

  logic [31:0] sh_res;
  logic sh_c;
  shift_kind_t sh_kind;
  logic [7:0] sh_amt;
  logic [31:0] cmp_b;
  logic [32:0] cmp_sum;
  logic [32:0] neg_sum;

  // Shift control; register form reads only the low byte
  assign sh_kind = (op_i == rotate_right_op) ? sk_ror :
                   (op_i == arith_shift_right) ? sk_asr :
                   (op_i == logic_shift_right) ? sk_lsr : sk_lsl;
  assign sh_amt = (imm_form_i && op_i != rotate_right_op) ? imm_i : second_src_i[7:0]; // RQ2 RQ3

  // Compare arithmetic for compare and compare negative
  assign cmp_b = imm_form_i ? {24'h00_0000, imm_i} : second_src_i;
  assign cmp_sum = add_carry(first_src_i, ~cmp_b, 1'b1); // RQ7
  assign neg_sum = add_carry(first_src_i, second_src_i, 1'b0); // RQ8

  shift_unit u_shift (
    .value_i(first_src_i),
    .amount_i(sh_amt),
    .kind_i(sh_kind),
    .carry_i(st_r.fc),
    .result_o(sh_res),
    .carry_o(sh_c)
  );

  // Next state: bus slave first, then the operation, which wins on the flags
  always_comb begin
    logic [31:0] res;
    logic wr;
    logic set_nz;
    res = WORD_RST;
    wr = 1'b0;
    set_nz = 1'b0;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.wr_en = 1'b0;
    st_nxt.branch = 1'b0;
    if (wb_cyc_i && wb_stb_i && !st_r.ack) begin
      st_nxt.ack = 1'b1;
      unique case (wb_adr_i)
        FLAGS_OFS: st_nxt.rdata = {st_r.fn, st_r.fz, st_r.fc, st_r.fv, 28'h000_0000};
        RESULT_OFS: st_nxt.rdata = st_r.result;
        COUNT_OFS: st_nxt.rdata = st_r.op_count;
        default: st_nxt.rdata = WORD_RST;
      endcase
      if (wb_we_i && wb_adr_i == FLAGS_OFS && wb_sel_i[FLAG_SEL_LANE]) begin
        st_nxt.fn = wb_dat_i[FLAG_N_POS];
        st_nxt.fz = wb_dat_i[FLAG_Z_POS];
        st_nxt.fc = wb_dat_i[FLAG_C_POS];
        st_nxt.fv = wb_dat_i[FLAG_V_POS];
      end
    end
    if (op_valid_i) begin
      // Software flag writes in the same cycle are overridden
      st_nxt.fn = st_r.fn;
      st_nxt.fz = st_r.fz;
      st_nxt.fc = st_r.fc;
      st_nxt.fv = st_r.fv;
      unique case (op_i)
        and_set_flags: begin
          res = first_src_i & second_src_i; // RQ1
          wr = 1'b1;
          set_nz = 1'b1;
        end
        or_set_flags: begin
          res = first_src_i | second_src_i; // RQ1
          wr = 1'b1;
          set_nz = 1'b1;
        end
        xor_set_flags: begin
          res = first_src_i ^ second_src_i; // RQ1
          wr = 1'b1;
          set_nz = 1'b1;
        end
        bit_clear_set_flags: begin
          res = first_src_i & ~second_src_i; // RQ23
          wr = 1'b1;
          set_nz = 1'b1;
        end
        logic_shift_left, logic_shift_right, arith_shift_right, rotate_right_op: begin
          res = sh_res; // RQ4
          wr = 1'b1;
          set_nz = 1'b1; // RQ5
          st_nxt.fc = sh_c; // RQ5
        end
        compare_op: begin
          res = cmp_sum[31:0];
          set_nz = 1'b1; // RQ9
          st_nxt.fc = cmp_sum[32]; // RQ9
          st_nxt.fv = add_ovf(first_src_i, ~cmp_b, cmp_sum[31:0]); // RQ9
        end
        compare_negative_op: begin
          res = neg_sum[31:0];
          set_nz = 1'b1; // RQ9
          st_nxt.fc = neg_sum[32]; // RQ9
          st_nxt.fv = add_ovf(first_src_i, second_src_i, neg_sum[31:0]); // RQ9
        end
        move_plain_op: begin
          res = first_src_i; // RQ11
          wr = (dest_idx_i != PC_IDX);
          if (dest_idx_i == PC_IDX) begin
            st_nxt.branch = 1'b1; // RQ14
            st_nxt.branch_addr = {first_src_i[31:1], 1'b0}; // RQ14
          end
        end
        move_set_flags: begin
          res = first_src_i; // RQ11
          wr = 1'b1;
          set_nz = 1'b1; // RQ11
        end
        move_imm_op: begin
          res = {24'h00_0000, imm_i}; // RQ13
          wr = 1'b1;
          set_nz = 1'b1;
        end
        move_not_op: begin
          res = ~first_src_i; // RQ12
          wr = 1'b1;
          set_nz = 1'b1;
        end
        multiply_op: begin
          res = first_src_i * second_src_i; // RQ15
          wr = 1'b1;
          set_nz = 1'b1; // RQ16
        end
        byte_reverse_word: begin
          res = {first_src_i[7:0], first_src_i[15:8], first_src_i[23:16], first_src_i[31:24]}; // RQ18
          wr = 1'b1;
        end
        byte_reverse_halves: begin
          res = {first_src_i[23:16], first_src_i[31:24], first_src_i[7:0], first_src_i[15:8]}; // RQ18
          wr = 1'b1;
        end
        byte_reverse_signed_half: begin
          res = {{16{first_src_i[7]}}, first_src_i[7:0], first_src_i[15:8]}; // RQ19
          wr = 1'b1;
        end
        sign_extend_byte: begin
          res = {{24{first_src_i[7]}}, first_src_i[7:0]}; // RQ20
          wr = 1'b1;
        end
        sign_extend_half: begin
          res = {{16{first_src_i[15]}}, first_src_i[15:0]}; // RQ21
          wr = 1'b1;
        end
        zero_extend_byte: begin
          res = {24'h00_0000, first_src_i[7:0]}; // RQ20
          wr = 1'b1;
        end
        zero_extend_half: begin
          res = {16'h0000, first_src_i[15:0]}; // RQ21
          wr = 1'b1;
        end
        bit_test_op: begin
          res = first_src_i & second_src_i; // RQ22
          set_nz = 1'b1; // RQ22
        end
        default: begin
          res = WORD_RST;
        end
      endcase
      if (set_nz) begin
        st_nxt.fn = res[31];
        st_nxt.fz = (res == WORD_RST);
      end
      // Result, write and flags all land on the same edge
      st_nxt.done = 1'b1; // RQ25
      st_nxt.wr_en = wr; // RQ7 RQ8
      st_nxt.wr_idx = dest_idx_i; // RQ6 RQ17
      if (wr) begin
        st_nxt.result = res;
      end
      st_nxt.op_count = st_r.op_count + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{result: WORD_RST, wr_en: 1'b0, wr_idx: IDX_RST, done: 1'b0, branch: 1'b0,
                branch_addr: WORD_RST, fn: FLAG_RST, fz: FLAG_RST, fc: FLAG_RST, fv: FLAG_RST,
                op_count: WORD_RST, ack: 1'b0, rdata: WORD_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign result_o = st_r.result;
  assign wr_en_o = st_r.wr_en;
  assign wr_idx_o = st_r.wr_idx;
  assign done_o = st_r.done;
  assign branch_o = st_r.branch;
  assign branch_addr_o = st_r.branch_addr;
  assign flag_n_o = st_r.fn;
  assign flag_z_o = st_r.fz;
  assign flag_c_o = st_r.fc;
  assign flag_v_o = st_r.fv;

  // Operand copies one cycle back for the checks below
  logic [31:0] h_a;
  logic [31:0] h_b;
  logic [7:0] h_imm;
  always_ff @(posedge clk_i) begin
    h_a <= first_src_i;
    h_b <= second_src_i;
    h_imm <= imm_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_logic_cv_hold: assert property (op_valid_i && op_i inside {and_set_flags, or_set_flags, xor_set_flags,
      bit_clear_set_flags} |=> $stable(flag_c_o) && $stable(flag_v_o)) // RQ1
    else $error("logical op changed C or V");
  a_and_zero_flag: assert property (op_valid_i && op_i == and_set_flags |=>
      flag_z_o == ((h_a & h_b) == 32'h0000_0000) && flag_n_o == result_o[31]) // RQ1
    else $error("AND flags wrong");
  a_shift_low_byte: assert property (op_valid_i && op_i == logic_shift_left && !imm_form_i |=>
      result_o == (h_a << h_b[7:0])) // RQ3
    else $error("register shift used more than the low byte");
  a_shift_zero_c: assert property (op_valid_i && op_i == logic_shift_right && imm_form_i && imm_i == 8'h00 |=>
      $stable(flag_c_o)) // RQ5
    else $error("zero-length shift changed carry");
  a_cmp_no_write: assert property (op_valid_i && op_i inside {compare_op, compare_negative_op, bit_test_op} |=>
      done_o && !wr_en_o) // RQ7
    else $error("compare or test wrote a register");
  a_cmpneg_carry: assert property (op_valid_i && op_i == compare_negative_op |=>
      flag_c_o == ((h_a + h_b) < h_a)) // RQ9
    else $error("compare negative carry wrong");
  a_pc_bit0: assert property (branch_o |-> branch_addr_o[0] == 1'b0 && !wr_en_o && done_o) // RQ14
    else $error("branch target bit 0 set or register written");
  a_mul_low_word: assert property (op_valid_i && op_i == multiply_op |=>
      result_o == h_a * h_b && $stable(flag_c_o)) // RQ15
    else $error("multiply result wrong");
  a_rev_signed: assert property (op_valid_i && op_i == byte_reverse_signed_half |=>
      result_o == {{16{h_a[7]}}, h_a[7:0], h_a[15:8]} && $stable({flag_n_o, flag_z_o})) // RQ19
    else $error("signed half reverse wrong");
  a_ext_flags_hold: assert property (op_valid_i && op_i inside {sign_extend_byte, sign_extend_half,
      zero_extend_byte, zero_extend_half} |=> $stable({flag_n_o, flag_z_o, flag_c_o, flag_v_o})) // RQ21
    else $error("extend changed a flag");
  a_one_cycle_done: assert property (op_valid_i |=> done_o ##1 (done_o == $past(op_valid_i))) // RQ25
    else $error("operation not done in one cycle");
  a_wb_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  // Move, reverse and bit clear results
  a_not_result: assert property (op_valid_i && op_i == move_not_op |=>
      result_o == ~h_a && wr_en_o) // RQ12
    else $error("move not wrong");
  a_imm_result: assert property (op_valid_i && op_i == move_imm_op |=>
      result_o == {24'h00_0000, h_imm} && wr_en_o) // RQ13
    else $error("move immediate wrong");
  a_move_nz: assert property (op_valid_i && op_i == move_set_flags |=>
      result_o == h_a && flag_n_o == h_a[31] && $stable({flag_c_o, flag_v_o})) // RQ11
    else $error("flag-setting move wrong");
  a_rev_halves: assert property (op_valid_i && op_i == byte_reverse_halves |=>
      result_o == {h_a[23:16], h_a[31:24], h_a[7:0], h_a[15:8]}) // RQ18
    else $error("halves reverse wrong");
  a_clear_result: assert property (op_valid_i && op_i == bit_clear_set_flags |=>
      result_o == (h_a & ~h_b) && wr_en_o) // RQ23
    else $error("bit clear wrong");

  // Compare and test flags
  a_cmp_borrow: assert property (op_valid_i && op_i == compare_op && !imm_form_i |=>
      flag_c_o == (h_a >= h_b) && flag_z_o == (h_a == h_b)) // RQ7 RQ9
    else $error("compare C or Z wrong");
  a_test_flags: assert property (op_valid_i && op_i == bit_test_op |=>
      flag_z_o == ((h_a & h_b) == 32'h0000_0000) && $stable(result_o)) // RQ22
    else $error("bit test wrong");

  // Shift end points
  a_wide_lsr_zero: assert property (op_valid_i && op_i == logic_shift_right && !imm_form_i &&
      second_src_i[7:0] >= 8'h20 |=> result_o == 32'h0000_0000) // RQ24
    else $error("long shift not zero");
  a_asr_imm_fill: assert property (op_valid_i && op_i == arith_shift_right && imm_form_i && imm_i == 8'h20 |=>
      result_o == {32{h_a[31]}}) // RQ2
    else $error("shift by 32 not sign fill");
endmodule
`default_nettype wire

//--- pkg/alu_pkg.sv
// What this block does
// [RQ1] AND, OR, XOR, bit clear set N and Z, keep C and V
// [RQ2] Immediate shifts: right shifts 1 to 32, left shift 0 to 31
// [RQ3] Register shift amount comes from the low byte only
// [RQ4] Rotate right wraps bits leaving the bottom back into the top
// [RQ5] Shifts set N and Z; C takes last bit out, kept when length is 0
// [RQ6] Caller uses low registers; register shifts write back to the shifted source
// [RQ7] Compare subtracts second operand from first, flags only, no write
// [RQ8] Compare negative adds both operands, flags only, no write
// [RQ9] Both compares update N, Z, C and V
// [RQ10] Caller keeps compare immediate 0 to 255 and legal register numbers
// [RQ11] Move copies source; flag form sets N and Z, keeps C and V
// [RQ12] Move not writes the inverted source
// [RQ13] Move immediate writes an 8-bit unsigned constant
// [RQ14] Move to PC clears bit 0, branches, leaves execution state alone
// [RQ15] Multiply writes the low 32 product bits, sign independent
// [RQ16] Multiply sets N and Z, keeps C and V
// [RQ17] Caller uses low registers and destination equal to second source
// [RQ18] Word reverse swaps all four bytes; halves reverse swaps bytes per halfword
// [RQ19] Signed half reverse swaps low bytes and sign extends; no flag change
// [RQ20] Byte extends take bits 7..0, signed replicates bit 7, unsigned zero fills
// [RQ21] Halfword extends take bits 15..0 with sign or zero fill; no flag change
// [RQ22] Bit test And_set_flags, sets flags like flag-setting AND, writes nothing
// [RQ23] Bit clear And_set_flags first operand with inverted second and writes it
// [RQ24] Register shifts of 32 or more give zero, or sign fill for arithmetic
// [RQ25] Every operation finishes in one cycle, result and flags on one edge
`default_nettype none
package alu_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] PC_IDX = 4'hF;
  // Register map, byte addresses
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  // Flag field positions in the flags register
  localparam int unsigned FLAG_N_POS = 31;
  localparam int unsigned FLAG_Z_POS = 30;
  localparam int unsigned FLAG_C_POS = 29;
  localparam int unsigned FLAG_V_POS = 28;
  localparam int unsigned FLAG_SEL_LANE = 3;
  // Reset values
  localparam logic FLAG_RST = 1'b0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0] IDX_RST = 4'h0;

  typedef enum logic [4:0] {
    and_set_flags = 5'h00,
    or_set_flags = 5'h01,
    xor_set_flags = 5'h02,
    bit_clear_set_flags = 5'h03,
    logic_shift_left = 5'h04,
    logic_shift_right = 5'h05,
    arith_shift_right = 5'h06,
    rotate_right_op = 5'h07,
    compare_op = 5'h08,
    compare_negative_op = 5'h09,
    move_plain_op = 5'h0A,
    move_set_flags = 5'h0B,
    move_imm_op = 5'h0C,
    move_not_op = 5'h0D,
    multiply_op = 5'h0E,
    byte_reverse_word = 5'h0F,
    byte_reverse_halves = 5'h10,
    byte_reverse_signed_half = 5'h11,
    sign_extend_byte = 5'h12,
    sign_extend_half = 5'h13,
    zero_extend_byte = 5'h14,
    zero_extend_half = 5'h15,
    bit_test_op = 5'h16
  } op_t;

  typedef enum logic [1:0] {
    sk_lsl = 2'h0,
    sk_lsr = 2'h1,
    sk_asr = 2'h2,
    sk_ror = 2'h3
  } shift_kind_t;
endpackage
`default_nettype wire

//--- core/shift_unit.sv
`default_nettype none
module shift_unit
  import alu_pkg::*;
(
  input wire logic [31:0] value_i,     // Value to shift
  input wire logic [7:0] amount_i,     // Shift length, 0 to 255
  input wire shift_kind_t kind_i,      // Shift or rotate kind
  input wire logic carry_i,            // Current carry flag
  output logic [31:0] result_o,        // Shifted value
  output logic carry_o                 // Carry after the shift
);
  logic [32:0] left_t;
  logic [32:0] right_t;
  logic signed [32:0] arith_t;
  logic [63:0] rot_t;

  // Extra bit beside the word catches the last bit shifted out
  always_comb begin
    left_t = {1'b0, value_i} << amount_i;
    right_t = {value_i, 1'b0} >> amount_i;
    arith_t = $signed({value_i, 1'b0}) >>> amount_i;
    rot_t = {value_i, value_i} >> amount_i[4:0];
    result_o = value_i;
    carry_o = carry_i;
    if (amount_i != 8'h00) begin // RQ5
      unique case (kind_i)
        sk_lsl: begin
          result_o = left_t[31:0]; // RQ24
          carry_o = left_t[32]; // RQ5
        end
        sk_lsr: begin
          result_o = right_t[32:1]; // RQ24
          carry_o = right_t[0]; // RQ5
        end
        sk_asr: begin
          result_o = arith_t[32:1]; // RQ24
          carry_o = arith_t[0]; // RQ5
        end
        sk_ror: begin
          result_o = rot_t[31:0]; // RQ4
          carry_o = rot_t[31]; // RQ5
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/reg_file_model.sv
`default_nettype none
module reg_file_model (
  input wire logic clk_i,           // Core clock
  input wire logic rst_i,           // Synchronous reset, active high
  input wire logic wr_en_i,         // Write pulse from the datapath
  input wire logic [3:0] wr_idx_i,  // Register to write
  input wire logic [31:0] wr_data_i, // Value to write
  input wire logic [2:0] rd_idx_i,  // Low register to look at
  output logic [31:0] rd_data_o     // Its current value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] regs [8];
  // Only the low bank is held; callers name no high register here
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) regs[i] <= 32'h0;
    end else if (wr_en_i && wr_idx_i < 4'h8) begin
      regs[wr_idx_i[2:0]] <= wr_data_i;
    end
  end
  // Read port is combinational
  assign rd_data_o = regs[rd_idx_i];
endmodule
`default_nettype wire

//--- verification/thumb_alu_shift_move_extend_tb.sv
`default_nettype none
module thumb_alu_shift_move_extend_tb import alu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic br;
    logic [3:0] idx;
    logic [3:0] nzcv;
    logic [31:0] res;
    logic [31:0] badr;
  } exp_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic op_valid_i = 1'b0;
  op_t op_i = and_set_flags;
  logic [31:0] first_src_i = 32'h0, second_src_i = 32'h0, wb_dat_i = 32'h0;
  logic [7:0] imm_i = 8'h0, wb_adr_i = 8'h0;
  logic imm_form_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] dest_idx_i = 4'h0, wb_sel_i = 4'h0, wr_idx_o;
  logic [2:0] rd_idx = 3'h0;
  logic [31:0] wb_dat_o, result_o, branch_addr_o, rd_data;
  logic wb_ack_o, wr_en_o, done_o, branch_o, flag_n_o, flag_z_o, flag_c_o, flag_v_o;
  logic [3:0] fl = 4'h0;
  logic [31:0] last_res = 32'h0, op_cnt = 32'h0;
  logic [31:0] rf [8] = '{default: 32'h0};
  logic [7:0] amts [6] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21, 8'hFF};
  exp_t op_q [$];
  logic [31:0] bus_q [$];
  int err_total = 0, cmp_count = 0, seed = 23675, cyc_cnt = 0;

  always #12.5 clk_i = ~clk_i;

  thumb_alu_shift_move_extend i_thumb_alu_shift_move_extend (
    .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .first_src_i(first_src_i), .second_src_i(second_src_i), .imm_i(imm_i),
    .imm_form_i(imm_form_i), .dest_idx_i(dest_idx_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .result_o(result_o),
    .wr_en_o(wr_en_o), .wr_idx_o(wr_idx_o), .done_o(done_o), .branch_o(branch_o),
    .branch_addr_o(branch_addr_o), .flag_n_o(flag_n_o), .flag_z_o(flag_z_o),
    .flag_c_o(flag_c_o), .flag_v_o(flag_v_o));

  reg_file_model i_reg_file_model (
    .clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en_o), .wr_idx_i(wr_idx_o),
    .wr_data_i(result_o), .rd_idx_i(rd_idx), .rd_data_o(rd_data));

  // Reports one mismatch
  task automatic miss(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmp_op(input exp_t e);
    cmp_count++;
    if (wr_en_o !== e.wr || branch_o !== e.br || result_o !== e.res || (e.wr && wr_idx_o !== e.idx)
        || {flag_n_o, flag_z_o, flag_c_o, flag_v_o} !== e.nzcv || (e.br && branch_addr_o !== e.badr))
      miss($sformatf("op result %h flags %b", result_o, {flag_n_o, flag_z_o, flag_c_o, flag_v_o}));
  endtask

  task automatic cmp_bus(input logic [31:0] x);
    cmp_count++;
    if (wb_dat_o !== x) miss($sformatf("read %h want %h", wb_dat_o, x));
  endtask

  task automatic cmp_rf(input logic [31:0] x);
    cmp_count++;
    if (rd_data !== x) miss($sformatf("register %0d holds %h", rd_idx, rd_data));
  endtask

  // Issues one operation and notes what must come back a cycle later
  task automatic op_go(input op_t o, input logic [31:0] a, input logic [31:0] b, input logic [7:0] im,
                       input logic imf, input logic [3:0] d);
    exp_t e;
    logic [63:0] t;
    logic signed [63:0] ts;
    logic [32:0] s;
    logic [31:0] r, bb;
    logic [7:0] n;
    logic w, nz;
    e = '0;
    w = 1'b1;
    nz = 1'b1;
    r = a;
    n = (imf && o != rotate_right_op) ? im : b[7:0];
    case (o)
      and_set_flags, bit_test_op: r = a & b;
      or_set_flags: r = a | b;
      xor_set_flags: r = a ^ b;
      bit_clear_set_flags: r = a & ~b;
      logic_shift_left: begin
        t = {32'h0, a} << n;
        r = t[31:0];
        if (n != 8'h0) fl[1] = t[32];
      end
      logic_shift_right, arith_shift_right: begin
        ts = {a, 32'h0};
        ts = ts >>> n;
        t = (o == arith_shift_right) ? ts : {a, 32'h0} >> n;
        r = t[63:32];
        if (n != 8'h0) fl[1] = t[31];
      end
      rotate_right_op: begin
        r = (a >> n[4:0]) | (a << (6'h20 - {1'b0, n[4:0]}));
        if (n != 8'h0) fl[1] = r[31];
      end
      compare_op, compare_negative_op: begin
        bb = (o == compare_op) ? ~(imf ? {24'h0, im} : b) : b;
        s = {1'b0, a} + {1'b0, bb} + {32'h0, o == compare_op};
        r = s[31:0];
        fl[1] = s[32];
        fl[0] = (a[31] == bb[31]) && (r[31] != a[31]);
      end
      move_plain_op: nz = 1'b0;
      move_imm_op: r = {24'h0, im};
      move_not_op: r = ~a;
      multiply_op: r = a * b;
      byte_reverse_word: r = {a[7:0], a[15:8], a[23:16], a[31:24]};
      byte_reverse_halves: r = {a[23:16], a[31:24], a[7:0], a[15:8]};
      byte_reverse_signed_half: r = {{16{a[7]}}, a[7:0], a[15:8]};
      sign_extend_byte: r = {{24{a[7]}}, a[7:0]};
      sign_extend_half: r = {{16{a[15]}}, a[15:0]};
      zero_extend_byte: r = {24'h0, a[7:0]};
      zero_extend_half: r = {16'h0, a[15:0]};
      move_set_flags: r = a;
      default: w = 1'b0;
    endcase
    if (o >= byte_reverse_word && o <= zero_extend_half) nz = 1'b0;
    if (o == compare_op || o == compare_negative_op || o == bit_test_op) w = 1'b0;
    if (o > bit_test_op) nz = 1'b0;
    if (nz) fl[3:2] = {r[31], r == 32'h0};
    e.br = (o == move_plain_op && d == PC_IDX);
    if (e.br) w = 1'b0;
    if (w) last_res = r;
    if (w && d < 4'h8) rf[d[2:0]] = r;
    e.wr = w;
    e.idx = d;
    e.nzcv = fl;
    e.res = last_res;
    e.badr = {a[31:1], 1'b0};
    op_q.push_back(e);
    op_cnt++;
    op_valid_i <= 1'b1;
    op_i <= o;
    first_src_i <= a;
    second_src_i <= b;
    imm_i <= im;
    imm_form_i <= imf;
    dest_idx_i <= d;
    @(posedge clk_i);
  endtask

  // Classic single Wishbone cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                    input logic [31:0] x);
    op_valid_i <= 1'b0;
    if (!w) bus_q.push_back(x);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
    if (w && a == FLAGS_OFS && s[FLAG_SEL_LANE]) fl = d[31:28];
  endtask

  task automatic conclude;
    if (op_q.size() != 0) err_total++;
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Takes the oldest note whenever a result or read answer shows
  always @(negedge clk_i) begin
    if (done_o === 1'b1) begin
      if (op_q.size() == 0) miss("done without request");
      else cmp_op(op_q.pop_front());
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && bus_q.size() != 0) cmp_bus(bus_q.pop_front());
  end

  // Cuts a hang short
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, FLAGS_OFS, 4'hF, 32'h0, 32'h0);
    wb(1'b0, 8'h0C, 4'hF, 32'h0, 32'h0);
    wb(1'b1, FLAGS_OFS, 4'h7, 32'hF000_0000, 32'h0);
    wb(1'b1, FLAGS_OFS, 4'h8, 32'h3000_0000, 32'h0);
    wb(1'b1, RESULT_OFS, 4'hF, 32'h5A5A_5A5A, 32'h0);
    wb(1'b0, FLAGS_OFS, 4'hF, 32'h0, 32'h3000_0000);
    // Logic and compare group with carry and overflow set beforehand
    op_go(and_set_flags, 32'h8000_00F0, 32'hF000_000F, 8'h0, 1'b0, 4'h1);
    op_go(bit_test_op, 32'h0F0F_0F0F, 32'hF0F0_F0F0, 8'h0, 1'b0, 4'h2);
    op_go(bit_clear_set_flags, 32'hFFFF_0000, 32'h0F0F_0F0F, 8'h0, 1'b0, 4'h2);
    op_go(compare_op, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 8'h0, 1'b0, 4'h3);
    op_go(compare_op, 32'h0000_00FF, 32'h0, 8'hFF, 1'b1, 4'h3);
    op_go(compare_negative_op, 32'h7FFF_FFFF, 32'h0000_0001, 8'h0, 1'b0, 4'h3);
    // Shift lengths at their edges, register and immediate forms
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 6; j++) begin
        op_go(op_t'(5'h04 + k[4:0]), $random(seed), {24'($random(seed)), amts[j]}, 8'h0, 1'b0,
              4'h4);
        if (amts[j] <= 8'h20) op_go(op_t'(5'h04 + k[4:0]), $random(seed), $random(seed), amts[j], 1'b1,
                                    4'h5);
      end
    end
    // Every code back to back, random operands, low registers only
    repeat (8) begin
      for (int k = 0; k <= 5'h17; k++) begin
        bit f;
        f = 1'($random(seed));
        op_go(op_t'(k[4:0]), $random(seed), $random(seed), f ? 8'($random(seed)) & 8'h1F : 8'($random(seed)), f,
              {1'b0, 3'($random(seed))});
      end
    end
    op_go(multiply_op, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 8'h0, 1'b0, 4'h6);
    op_go(move_imm_op, 32'h0, 32'h0, 8'hFF, 1'b0, 4'h7);
    op_go(move_plain_op, 32'h1234_5679, 32'h0, 8'h0, 1'b0, PC_IDX);
    wb(1'b0, COUNT_OFS, 4'hF, 32'h0, op_cnt);
    wb(1'b0, RESULT_OFS, 4'hF, 32'h0, last_res);
    // Register file holds the last value written to each low register
    for (int i = 0; i < 8; i++) begin
      rd_idx <= 3'(i);
      @(negedge clk_i);
      cmp_rf(rf[i]);
    end
    conclude();
  end
endmodule
`default_nettype wire
